/* core/fmo_pkg.sv */
// Package of constants shared by both ends of the offset setup link.
package fmo_pkg;
  localparam int OFS_W = 11;
  localparam int SER_BITS = 44;
  localparam logic [10:0] PRE_64 = 11'h040;
  localparam logic [10:0] PRE_16 = 11'h010;
  localparam logic [10:0] PRE_8 = 11'h008;
  localparam logic [10:0] PRE_256 = 11'h100;
  localparam logic [10:0] PRE_1024 = 11'h400;
  localparam logic [10:0] OFS_MIN = 11'h001;
  localparam logic [10:0] OFS_MAX = 11'h7fc;
  // Host register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  // Control fields.
  localparam int CTRL_GO = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_IP = 2;
  localparam int CTRL_FS_LO = 4;
  localparam int CTRL_ET = 7;
  localparam int CTRL_BOTH = 8;
  localparam logic [7:0] RST_CYCLES = 8'h04;
  typedef enum logic [1:0] {FMO_PRE, FMO_PAR, FMO_SER} fmo_prog_e;
endpackage

/* core/fmo_link_if.sv */
// Interface joining the offset setup device end and its host end.
`timescale 1ns/1ps
interface fmo_link_if;
  logic fifo1_master_reset_n;
  logic fifo2_master_reset_n;
  logic endian_timing_select;
  logic flag_select0_serial_data;
  logic flag_select1_serial_enable;
  logic flag_select2;
  logic [35:0] port_a_data;
  logic port_a_write;
  logic port_a_full_flag;
  logic port_c_full_flag;
  modport device (input fifo1_master_reset_n, fifo2_master_reset_n, endian_timing_select,
    flag_select0_serial_data, flag_select1_serial_enable, flag_select2, port_a_data,
    port_a_write, output port_a_full_flag, port_c_full_flag);
  modport host (output fifo1_master_reset_n, fifo2_master_reset_n, endian_timing_select,
    flag_select0_serial_data, flag_select1_serial_enable, flag_select2, port_a_data,
    port_a_write, input port_a_full_flag, port_c_full_flag);
endinterface

/* core/fmo_device.sv */
// Device end: timing mode capture and almost flag offset loading.
`timescale 1ns/1ps
module fmo_device
  import fmo_pkg::*;
(
  input wire logic pclk, // Port A and port C clock.
  input wire logic presetn, // Power-on reset, active low.
  fmo_link_if.device lnk, // Pins from the host.
  output logic fifo1_fall_through, // FIFO1 in fall-through mode.
  output logic fifo2_fall_through, // FIFO2 in fall-through mode.
  output logic [10:0] portb_almost_empty_offset, // FIFO1 almost-empty offset.
  output logic [10:0] porta_almost_full_offset, // FIFO1 almost-full offset.
  output logic [10:0] porta_almost_empty_offset, // FIFO2 almost-empty offset.
  output logic [10:0] portc_almost_full_offset, // FIFO2 almost-full offset.
  output logic config_done // Offsets loaded, FIFOs usable.
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] m1_s, m2_s;
  logic m1_reg, m2_reg, m1_prev_reg, m2_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m1_s <= 3'h0;
      m2_s <= 3'h0;
    end else begin
      m1_s <= {m1_s[1:0], lnk.fifo1_master_reset_n};
      m2_s <= {m2_s[1:0], lnk.fifo2_master_reset_n};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m1_reg <= 1'b0;
      m2_reg <= 1'b0;
      m1_prev_reg <= 1'b0;
      m2_prev_reg <= 1'b0;
    end else begin
      if (m1_s[1] == m1_s[2]) m1_reg <= m1_s[2];
      if (m2_s[1] == m2_s[2]) m2_reg <= m2_s[2];
      m1_prev_reg <= m1_reg;
      m2_prev_reg <= m2_reg;
    end
  end
  wire rise1 = m1_reg && !m1_prev_reg;
  wire rise2 = m2_reg && !m2_prev_reg;
  wire both_rise = rise1 && rise2;
  wire [2:0] fs = {lnk.flag_select2, lnk.flag_select1_serial_enable,
                   lnk.flag_select0_serial_data};

  function automatic logic [10:0] preset_of(input logic [2:0] code);
    unique case (code)
      3'h7: preset_of = PRE_64;
      3'h6: preset_of = PRE_16;
      3'h5: preset_of = PRE_8;
      3'h3: preset_of = PRE_256;
      3'h1: preset_of = PRE_1024;
      default: preset_of = 11'h000;
    endcase
  endfunction

  // ****************************************
  // Mode capture
  // ****************************************
  fmo_prog_e prog_reg;
  logic ip_reg, arm1_reg, arm2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_reg <= FMO_PRE;
      ip_reg <= 1'b0;
    end else if (both_rise) begin
      if (fs == 3'h2) begin
        prog_reg <= FMO_SER;
        ip_reg <= 1'b0;
      end else if (fs[1:0] == 2'h0) begin
        prog_reg <= FMO_PAR;
        ip_reg <= !fs[2];
      end else begin
        prog_reg <= FMO_PRE;
        ip_reg <= 1'b0;
      end
    end else if (rise1) begin
      prog_reg <= FMO_PRE;
      ip_reg <= 1'b0;
    end
  end
  // Timing select is sampled on the second edge after the synchronised reset rises.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm1_reg <= 1'b0;
      arm2_reg <= 1'b0;
      fifo1_fall_through <= 1'b0;
      fifo2_fall_through <= 1'b0;
    end else begin
      arm1_reg <= rise1;
      arm2_reg <= rise2;
      if (arm1_reg) fifo1_fall_through <= !lnk.endian_timing_select;
      if (arm2_reg) fifo2_fall_through <= !lnk.endian_timing_select;
    end
  end

  // ****************************************
  // Offset loading
  // ****************************************
  logic [1:0] wcnt_reg;
  logic [5:0] scnt_reg;
  logic loading_reg;
  wire [10:0] par_val = ip_reg ? {lnk.port_a_data[11:9], lnk.port_a_data[7:0]}
                               : lnk.port_a_data[10:0];
  wire ser_shift = loading_reg && prog_reg == FMO_SER && !lnk.flag_select1_serial_enable;
  wire par_wr = loading_reg && prog_reg == FMO_PAR && lnk.port_a_write;
  wire [43:0] chain = {porta_almost_full_offset, portb_almost_empty_offset,
                       portc_almost_full_offset, porta_almost_empty_offset};
  wire [43:0] chain_next = {chain[42:0], lnk.flag_select0_serial_data};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portb_almost_empty_offset <= 11'h000;
      porta_almost_full_offset <= 11'h000;
      porta_almost_empty_offset <= 11'h000;
      portc_almost_full_offset <= 11'h000;
    end else if (rise1 || rise2) begin
      if (rise1) begin
        portb_almost_empty_offset <= preset_of(fs);
        porta_almost_full_offset <= preset_of(fs);
      end
      // A FIFO1 reset on its own leaves the FIFO2 offsets untouched.
      if (rise2) begin
        porta_almost_empty_offset <= both_rise ? preset_of(fs) : 11'h000;
        portc_almost_full_offset <= both_rise ? preset_of(fs) : 11'h000;
      end
    end else if (ser_shift) begin
      {porta_almost_full_offset, portb_almost_empty_offset,
       portc_almost_full_offset, porta_almost_empty_offset} <= chain_next;
    end else if (par_wr) begin
      unique case (wcnt_reg)
        2'h0: porta_almost_full_offset <= par_val;
        2'h1: portb_almost_empty_offset <= par_val;
        2'h2: portc_almost_full_offset <= par_val;
        2'h3: porta_almost_empty_offset <= par_val;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loading_reg <= 1'b0;
      wcnt_reg <= 2'h0;
      scnt_reg <= 6'h00;
    end else if (both_rise) begin
      loading_reg <= (fs == 3'h2) || (fs[1:0] == 2'h0);
      wcnt_reg <= 2'h0;
      scnt_reg <= 6'h00;
    end else if (!m1_reg || !m2_reg) begin
      loading_reg <= 1'b0;
    end else if (ser_shift) begin
      scnt_reg <= scnt_reg + 6'h01;
      if (scnt_reg == 6'(SER_BITS - 1)) loading_reg <= 1'b0;
    end else if (par_wr) begin
      wcnt_reg <= wcnt_reg + 2'h1;
      if (wcnt_reg == 2'h3) loading_reg <= 1'b0;
    end
  end

  // ****************************************
  // Ready flags
  // ****************************************
  // Flags follow reset plus two cycles; port C stays low during any offset load, port A only during a serial load.
  logic [1:0] rdy1_reg, rdy2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy1_reg <= 2'h0;
      rdy2_reg <= 2'h0;
      lnk.port_a_full_flag <= 1'b0;
      lnk.port_c_full_flag <= 1'b0;
      config_done <= 1'b0;
    end else begin
      rdy1_reg <= (m1_reg && !rise1) ? {rdy1_reg[0], 1'b1} : 2'h0;
      rdy2_reg <= (m2_reg && !rise2) ? {rdy2_reg[0], 1'b1} : 2'h0;
      lnk.port_a_full_flag <= rdy1_reg[1] && !both_rise
        && !(loading_reg && prog_reg == FMO_SER);
      lnk.port_c_full_flag <= rdy2_reg[1] && !loading_reg && !both_rise;
      config_done <= rdy1_reg[1] && rdy2_reg[1] && !loading_reg && !both_rise;
    end
  end
  // Port A stays open during a parallel load, because the offset words arrive as FIFO1 writes.
  // Mode outputs tell the downstream FIFO which flag meaning to use.
endmodule // fmo_device

/* core/fmo_host.sv */
// Host end: drives resets, selects and offset writes from APB orders.
`timescale 1ns/1ps
module fmo_host
  import fmo_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  fmo_link_if.host lnk // Pins to the device.
);
  logic [8:0] ctrl_reg;
  logic [7:0] rcnt_reg;
  logic [5:0] bit_reg;
  logic [43:0] sh_reg;
  logic busy_reg;
  wire acc = psel && penable;
  // Serial words are queued while port A is still closed by the load.
  wire wr_ok = (lnk.port_a_full_flag || ctrl_reg[CTRL_SERIAL]) && !busy_reg;
  // ****************************************
  // APB slave
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !(paddr == ADDR_CTRL || paddr == ADDR_STAT
        || (paddr == ADDR_DATA && (!pwrite || wr_ok)));
      unique case (paddr)
        ADDR_CTRL: prdata <= {23'h0, ctrl_reg};
        ADDR_STAT: prdata <= {29'h0, busy_reg, lnk.port_c_full_flag, lnk.port_a_full_flag};
        default: prdata <= 32'h0;
      endcase
    end
  end
  // ****************************************
  // Link sequencing
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 9'h0;
      rcnt_reg <= 8'h0;
      busy_reg <= 1'b0;
      bit_reg <= 6'h0;
      sh_reg <= 44'h0;
      lnk.fifo1_master_reset_n <= 1'b0;
      lnk.fifo2_master_reset_n <= 1'b0;
      lnk.endian_timing_select <= 1'b0;
      lnk.flag_select0_serial_data <= 1'b0;
      lnk.flag_select1_serial_enable <= 1'b0;
      lnk.flag_select2 <= 1'b0;
      lnk.port_a_data <= 36'h0;
      lnk.port_a_write <= 1'b0;
    end else begin
      lnk.port_a_write <= 1'b0;
      if (acc && pready && pwrite && paddr == ADDR_CTRL && !busy_reg) begin
        ctrl_reg <= pwdata[8:0];
        if (pwdata[CTRL_GO]) begin
          busy_reg <= 1'b1;
          rcnt_reg <= RST_CYCLES + RST_CYCLES;
          lnk.fifo1_master_reset_n <= 1'b0;
          lnk.fifo2_master_reset_n <= !pwdata[CTRL_BOTH];
          {lnk.flag_select2, lnk.flag_select1_serial_enable, lnk.flag_select0_serial_data}
            <= pwdata[CTRL_FS_LO +: 3];
          lnk.endian_timing_select <= pwdata[CTRL_ET];
        end
      end else if (acc && pready && pwrite && paddr == ADDR_DATA && wr_ok) begin
        if (ctrl_reg[CTRL_SERIAL]) begin
          sh_reg <= {sh_reg[32:0], pwdata[10:0]}; // The first word ends in the top bits.
          bit_reg <= bit_reg + 6'd11;
          if (bit_reg == 6'd33) busy_reg <= 1'b1;
        end else begin
          lnk.port_a_data <= ctrl_reg[CTRL_IP]
            ? {24'h0, pwdata[10:8], pwdata[11], pwdata[7:0]} : {25'h0, pwdata[10:0]};
          lnk.port_a_write <= 1'b1;
        end
      end else if (busy_reg && rcnt_reg != 8'h0) begin
        rcnt_reg <= rcnt_reg - 8'h01;
        if (rcnt_reg == 8'h01) begin
          lnk.fifo1_master_reset_n <= 1'b1;
          lnk.fifo2_master_reset_n <= 1'b1;
          busy_reg <= 1'b0;
          bit_reg <= 6'h0;
          if (ctrl_reg[CTRL_FS_LO +: 2] == 2'h0)
            {lnk.flag_select1_serial_enable, lnk.flag_select0_serial_data} <= 2'h0;
        end
      end else if (busy_reg && bit_reg != 6'h0) begin
        lnk.flag_select1_serial_enable <= 1'b0;
        lnk.flag_select0_serial_data <= sh_reg[43];
        sh_reg <= {sh_reg[42:0], 1'b0};
        bit_reg <= bit_reg - 6'h01;
        if (bit_reg == 6'h1) busy_reg <= 1'b0;
      end else begin
        lnk.flag_select1_serial_enable <= ctrl_reg[CTRL_SERIAL] ? 1'b1
          : lnk.flag_select1_serial_enable;
      end
    end
  end
endmodule // fmo_host

/* tb/fmo_properties.sv */
// Concurrent checks on the link between the host end and the device end.
`timescale 1ns/1ps
module fmo_properties (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic fifo1_master_reset_n, // FIFO1 reset.
  input wire logic fifo2_master_reset_n, // FIFO2 reset.
  input wire logic endian_timing_select, // Mode pin.
  input wire logic flag_select0_serial_data, // Select 0.
  input wire logic flag_select1_serial_enable, // Select 1.
  input wire logic flag_select2, // Select 2.
  input wire logic [35:0] port_a_data, // Data.
  input wire logic port_a_write, // Write pulse.
  input wire logic port_a_full_flag, // Port A flag.
  input wire logic port_c_full_flag // Port C flag.
);
  // ****************************************
  // Selects captured at reset and counters.
  // ****************************************
  logic [2:0] fs_reg;
  logic [2:0] wr_reg;
  logic [5:0] bit_reg;
  logic ser;
  logic par;
  assign ser = fs_reg == 3'h2;
  assign par = fs_reg[1:0] == 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fs_reg <= 3'h0;
    else if (!fifo1_master_reset_n)
      fs_reg <= {flag_select2, flag_select1_serial_enable, flag_select0_serial_data};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_reg <= 3'h0;
    else if (!fifo1_master_reset_n) wr_reg <= 3'h0;
    else if (port_a_write && wr_reg != 3'h7) wr_reg <= wr_reg + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bit_reg <= 6'h0;
    else if (!fifo1_master_reset_n) bit_reg <= 6'h0;
    else if (ser && !flag_select1_serial_enable && bit_reg != 6'h3f) bit_reg <= bit_reg + 6'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  par_wait_a: assert property (par && $rose(port_c_full_flag) |-> wr_reg >= 3'h4)
    else $error("port C flag high before four offset writes");
  par_rise_a: assert property (par && port_a_write && wr_reg == 3'h3
    |-> ##[1:8] port_c_full_flag)
    else $error("port C flag late after the last offset write");
  ser_a_wait_a: assert property (ser && $rose(port_a_full_flag) |-> bit_reg >= 6'h2c)
    else $error("port A flag rose before all serial bits");
  ser_c_wait_a: assert property (ser && $rose(port_c_full_flag) |-> bit_reg >= 6'h2c)
    else $error("port C flag rose before all serial bits");
  ser_rise_a: assert property (ser && !flag_select1_serial_enable
    && fifo1_master_reset_n && bit_reg == 6'h2b |-> ##[1:8] port_a_full_flag)
    else $error("port A flag late after the last serial bit");
  preset_rise_a: assert property ($rose(fifo1_master_reset_n) && !ser && !par
    |-> ##[1:16] port_a_full_flag)
    else $error("port A flag late after a preset reset");
  reset_a_low_a: assert property ($fell(fifo1_master_reset_n)
    |-> ##[0:6] !port_a_full_flag)
    else $error("port A flag not cleared by reset");
  reset_c_low_a: assert property ($fell(fifo2_master_reset_n)
    |-> ##[0:6] !port_c_full_flag)
    else $error("port C flag not cleared by reset");
  cover property (par && $rose(port_c_full_flag));
  cover property (ser && $rose(port_a_full_flag));
  cover property ($rose(fifo1_master_reset_n) && fifo2_master_reset_n);
endmodule // fmo_properties

/* tb/fifo_mode_and_flag_offset_setup_tb_top.sv */
// Bench driving the host end over APB and watching the device end.
`timescale 1ns/1ps
module fifo_mode_and_flag_offset_setup_tb_top;
  import fmo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, config_done, done_q, ft1, ft2;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] ae1, af1, ae2, af2;
  logic [45:0] last_cfg;
  logic [45:0] cfg_q[$];
  logic [33:0] apb_q[$];
  logic [2:0] ps [5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
  int error_cnt, tests_run;
  fmo_link_if lnk();
  fmo_host fmo_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  fmo_device fmo_device_inst(.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .fifo1_fall_through(ft1), .fifo2_fall_through(ft2), .portb_almost_empty_offset(ae1),
    .porta_almost_full_offset(af1), .porta_almost_empty_offset(ae2),
    .portc_almost_full_offset(af2), .config_done(config_done));
  fmo_properties fmo_properties_inst(.pclk(pclk), .presetn(presetn),
    .fifo1_master_reset_n(lnk.fifo1_master_reset_n),
    .fifo2_master_reset_n(lnk.fifo2_master_reset_n),
    .endian_timing_select(lnk.endian_timing_select),
    .flag_select0_serial_data(lnk.flag_select0_serial_data),
    .flag_select1_serial_enable(lnk.flag_select1_serial_enable),
    .flag_select2(lnk.flag_select2), .port_a_data(lnk.port_a_data),
    .port_a_write(lnk.port_a_write), .port_a_full_flag(lnk.port_a_full_flag),
    .port_c_full_flag(lnk.port_c_full_flag));
  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic check(input logic [45:0] seen, input logic [45:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeout();
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    final_report();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] e);
    int n;
    apb_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) timeout();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [10:0] pre(input logic [2:0] fs);
    case (fs)
      3'h7: return PRE_64;
      3'h6: return PRE_16;
      3'h5: return PRE_8;
      3'h3: return PRE_256;
      default: return PRE_1024;
    endcase
  endfunction
  // Offsets go out in the order af1, ae1, af2, ae2.
  task automatic run_cfg(input logic [2:0] fs, input logic ip, ser, both, et);
    logic [10:0] o [4];
    logic [31:0] w;
    logic prog;
    int n;
    prog = ser || fs[1:0] == 2'h0;
    for (n = 0; n < 4; n++) o[n] = prog ? 11'h1 + 11'($urandom % 2044) : pre(fs);
    if (!both) o[2] = last_cfg[21:11];
    if (!both) o[3] = last_cfg[10:0];
    last_cfg = {~et, both ? ~et : last_cfg[44], o[0], o[1], o[2], o[3]};
    cfg_q.push_back(last_cfg);
    apb(1'b1, ADDR_CTRL, {23'h0, both, et, fs, 1'b0, ip, ser, 1'b1}, 34'h0);
    apb(1'b1, ADDR_DATA, 32'h1, {2'h1, 32'h0});
    for (n = 0; n < 100; n++) begin
      apb(1'b0, ADDR_STAT, 32'h0, {1'b1, 33'h0});
      if (rd[2] === 1'b0 && (ser || rd[0] === 1'b1)) break;
    end
    if (n == 100) timeout();
    apb(1'b0, ADDR_CTRL, 32'h0, {2'h0, 23'h0, both, et, fs, 1'b0, ip, ser, 1'b1});
    for (n = 0; n < 4 && prog; n++) begin
      // Bit 11 is random; only in interspersed mode does it reach the device, on the parity line that the device ignores.
      w = $urandom;
      w[10:0] = o[n];
      apb(1'b1, ADDR_DATA, w, {ser, 33'h0});
    end
    for (n = 0; n < 400 && cfg_q.size() != 0; n++) @(posedge pclk);
    if (cfg_q.size() != 0) timeout();
    check({45'h0, lnk.endian_timing_select}, {45'h0, et});
    if (prog && !ser)
      check({44'h0, lnk.flag_select1_serial_enable, lnk.flag_select0_serial_data},
        46'h0);
    $display("test done: selects %b interspersed %b serial %b both %b", fs, ip, ser, both);
  endtask
  // ****************************************
  // Result watcher.
  // ****************************************
  always @(posedge pclk) begin
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = apb_q.size() != 0 ? apb_q.pop_front() : 34'h1;
      if (!e[33])
        check({13'h0, pslverr, pwrite ? 32'h0 : prdata}, {13'h0, e[32:0]});
    end
    if (config_done === 1'b1 && done_q !== 1'b1) begin
      if (cfg_q.size() == 0) check(46'h1, 46'h0);
      else check({ft1, ft2, af1, ae1, af2, ae2},
        cfg_q.pop_front());
    end
    done_q <= config_done;
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    last_cfg = 46'h0;
    void'($urandom(32'h4fe3));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ps[i]) run_cfg(ps[i], 1'b0, 1'b0, 1'b1, 1'($urandom));
    run_cfg(3'h7, 1'b0, 1'b0, 1'b0, 1'($urandom));
    run_cfg(3'h4, 1'b0, 1'b0, 1'b1, 1'($urandom));
    run_cfg(3'h0, 1'b1, 1'b0, 1'b1, 1'($urandom));
    run_cfg(3'h2, 1'b0, 1'b1, 1'b1, 1'($urandom));
    apb(1'b0, 8'h0c, 32'h0, {2'h1, 32'h0});
    $display("test done: unmapped read");
    final_report();
  end
endmodule // fifo_mode_and_flag_offset_setup_tb_top
